// File: pcba_consts.vh
// Register map, field positions and reset values of the port configuration block
`ifndef PCBA_CONSTS_VH
`define PCBA_CONSTS_VH

// ==========================================================================
// Register byte offsets
`define PCBA_OFS_P9_OD        12'h000
`define PCBA_OFS_P9_OD_HI     12'h004
`define PCBA_OFS_DL_LATCH     12'h008
`define PCBA_OFS_DL_LATCH_HI  12'h00C
`define PCBA_OFS_DL_DIR       12'h010
`define PCBA_OFS_DL_DIR_HI    12'h014
`define PCBA_OFS_DL_FSEL      12'h018
`define PCBA_OFS_DL_FSEL_HI   12'h01C
`define PCBA_OFS_P9_FCTRL     12'h020
`define PCBA_OFS_P9_FEXT      12'h024
`define PCBA_OFS_BUS_CFG      12'h028
`define PCBA_OFS_SHARED_CFG   12'h02C
`define PCBA_OFS_STATUS       12'h030
`define PCBA_OFS_DL_PINS      12'h034

// ==========================================================================
// Reset values
`define PCBA_RST_P9_OD        16'h0000
`define PCBA_RST_DL_LATCH     16'h0000
`define PCBA_RST_DL_DIR       16'hFFFF
`define PCBA_RST_DL_FSEL      16'h0000
`define PCBA_RST_P9_FCTRL     16'h0000
`define PCBA_RST_P9_FEXT      16'h0000

// ==========================================================================
// Field positions
`define PCBA_BUS_SEP_BIT      8
`define PCBA_SH_FALL_BIT      0
`define PCBA_SH_RISE_BIT      1
`define PCBA_SH_RX0EN_BIT     2
`define PCBA_ST_RX1_KR_BIT    0
`define PCBA_ST_UPPER_AD_BIT  1
`define PCBA_ST_IRQ7_RX0_BIT  2
`define PCBA_P9_SHARED_BIT    1
`define PCBA_BUS_SIZE_8BIT    8'h00

`endif

// File: pcba_alias_reg.v
// Control register with full-width access and a high-byte alias
`timescale 1ns/10ps
`default_nettype none

module pcba_alias_reg #(
  parameter [15:0] RESET_VALUE = 16'h0000
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // Write requests
  input  wire        wr_full,
  input  wire        wr_high,
  input  wire [1:0]  strb,
  input  wire [15:0] wdata,
  // Stored value
  output reg  [15:0] q
);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RESET_VALUE;
    end else if (wr_full) begin
      if (strb[0]) begin
        q[7:0] <= wdata[7:0];
      end
      if (strb[1]) begin
        q[15:8] <= wdata[15:8];
      end
    end else if (wr_high && strb[0]) begin
      // Alias lane 0 lands in the upper byte; lower byte untouched [R11]
      q[15:8] <= wdata[7:0];
    end
  end

endmodule

`default_nettype wire

// File: pcba_port_cfg.v
// Port 9 and data port configuration with byte aliases and shared-pin routing
// Notes on behaviour
// R1: Never enable serial1 receive and key return together
// R2: Key return: function bit 1, extension bit 0
// R3: Pulled-up port 9 outputs need open-drain set
// R4: Port 9 open-drain upper byte has alias
// R5: Data port latch upper byte has alias
// R6: Data port direction upper byte has alias
// R7: Data port function-select upper byte has alias
// R8: Separate 8-bit bus: no alternate upper pins
// R9: Serial0 use: clear interrupt 7 edge enables
// R10: Interrupt 7 use: clear serial0 receive enable
// R11: Alias writes touch only upper byte
`timescale 1ns/10ps
`default_nettype none
`include "pcba_consts.vh"

module pcba_port_cfg (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Port 9 output stage
  input  wire [15:0] p9_port_data,
  input  wire [15:0] p9_port_drive,
  input  wire [15:0] p9_pin_in,
  output reg  [15:0] p9_pin_out,
  output reg  [15:0] p9_pin_oe,
  // Shared port 9 pin consumers
  output reg         serial1_receive_in,
  output reg         key_return_in_7,
  // Data port pins
  input  wire [15:0] dl_pin_in,
  output reg  [15:0] dl_pin_out,
  output reg  [15:0] dl_pin_oe,
  // Bus controller alternate function
  input  wire [15:0] ad_alt_out,
  input  wire [15:0] ad_alt_oe,
  output reg  [15:0] ad_alt_in,
  // External interrupt 7 and serial 0 shared pin
  input  wire        irq7_rx0_pin_in,
  output reg         serial0_receive_in,
  output reg         external_interrupt_7,
  output reg         ext_irq7_falling_enable,
  output reg         ext_irq7_rising_enable,
  output reg         serial0_receive_enable
);

  // ========================================================================
  // APB handshake
  // One wait state: pready rises in the second access cycle, and writes
  // commit on the edge that sees pready high.
  wire        access   = psel && penable;
  wire        commit   = access && pready;
  wire        wr_cycle = commit && pwrite;

  wire        hit_od      = (paddr == `PCBA_OFS_P9_OD);
  wire        hit_od_hi   = (paddr == `PCBA_OFS_P9_OD_HI);
  wire        hit_lat     = (paddr == `PCBA_OFS_DL_LATCH);
  wire        hit_lat_hi  = (paddr == `PCBA_OFS_DL_LATCH_HI);
  wire        hit_dir     = (paddr == `PCBA_OFS_DL_DIR);
  wire        hit_dir_hi  = (paddr == `PCBA_OFS_DL_DIR_HI);
  wire        hit_fsel    = (paddr == `PCBA_OFS_DL_FSEL);
  wire        hit_fsel_hi = (paddr == `PCBA_OFS_DL_FSEL_HI);
  wire        hit_fctrl   = (paddr == `PCBA_OFS_P9_FCTRL);
  wire        hit_fext    = (paddr == `PCBA_OFS_P9_FEXT);
  wire        hit_bus     = (paddr == `PCBA_OFS_BUS_CFG);
  wire        hit_shared  = (paddr == `PCBA_OFS_SHARED_CFG);
  wire        hit_status  = (paddr == `PCBA_OFS_STATUS);
  wire        hit_pins    = (paddr == `PCBA_OFS_DL_PINS);

  // ========================================================================
  // 16-bit registers; the first four have a high-byte alias
  wire [15:0] port9_open_drain_select;
  wire [15:0] data_port_output_latch;
  wire [15:0] data_port_direction;
  wire [15:0] data_port_function_select;
  wire [15:0] port9_function_ctrl;
  wire [15:0] port9_function_ext;

  // [R4]
  pcba_alias_reg #(.RESET_VALUE(`PCBA_RST_P9_OD)) u_p9_od (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_full (wr_cycle && hit_od),
    .wr_high (wr_cycle && hit_od_hi),
    .strb    (pstrb[1:0]),
    .wdata   (pwdata[15:0]),
    .q       (port9_open_drain_select)
  );

  // [R5]
  pcba_alias_reg #(.RESET_VALUE(`PCBA_RST_DL_LATCH)) u_dl_lat (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_full (wr_cycle && hit_lat),
    .wr_high (wr_cycle && hit_lat_hi),
    .strb    (pstrb[1:0]),
    .wdata   (pwdata[15:0]),
    .q       (data_port_output_latch)
  );

  // [R6]
  pcba_alias_reg #(.RESET_VALUE(`PCBA_RST_DL_DIR)) u_dl_dir (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_full (wr_cycle && hit_dir),
    .wr_high (wr_cycle && hit_dir_hi),
    .strb    (pstrb[1:0]),
    .wdata   (pwdata[15:0]),
    .q       (data_port_direction)
  );

  // [R7]
  pcba_alias_reg #(.RESET_VALUE(`PCBA_RST_DL_FSEL)) u_dl_fsel (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_full (wr_cycle && hit_fsel),
    .wr_high (wr_cycle && hit_fsel_hi),
    .strb    (pstrb[1:0]),
    .wdata   (pwdata[15:0]),
    .q       (data_port_function_select)
  );

  // Function control words have no alias of their own here
  pcba_alias_reg #(.RESET_VALUE(`PCBA_RST_P9_FCTRL)) u_p9_fctrl (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_full (wr_cycle && hit_fctrl),
    .wr_high (1'b0),
    .strb    (pstrb[1:0]),
    .wdata   (pwdata[15:0]),
    .q       (port9_function_ctrl)
  );

  pcba_alias_reg #(.RESET_VALUE(`PCBA_RST_P9_FEXT)) u_p9_fext (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_full (wr_cycle && hit_fext),
    .wr_high (1'b0),
    .strb    (pstrb[1:0]),
    .wdata   (pwdata[15:0]),
    .q       (port9_function_ext)
  );

  // ========================================================================
  // Bus mode and shared-pin control bits
  reg         separate_bus_mode_bit;
  reg  [7:0]  bus_size_bits;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      separate_bus_mode_bit   <= 1'b0;
      bus_size_bits           <= 8'h00;
      ext_irq7_falling_enable <= 1'b0;
      ext_irq7_rising_enable  <= 1'b0;
      serial0_receive_enable  <= 1'b0;
    end else if (wr_cycle) begin
      if (hit_bus) begin
        if (pstrb[0]) begin
          bus_size_bits <= pwdata[7:0];
        end
        if (pstrb[1]) begin
          separate_bus_mode_bit <= pwdata[`PCBA_BUS_SEP_BIT];
        end
      end else if (hit_shared && pstrb[0]) begin
        ext_irq7_falling_enable <= pwdata[`PCBA_SH_FALL_BIT];
        ext_irq7_rising_enable  <= pwdata[`PCBA_SH_RISE_BIT];
        serial0_receive_enable  <= pwdata[`PCBA_SH_RX0EN_BIT];
      end
    end
  end

  // ========================================================================
  // Shared-pin selection and misuse detection
  wire        kr_bit_fc  = port9_function_ctrl[`PCBA_P9_SHARED_BIT];
  wire        kr_bit_fe  = port9_function_ext[`PCBA_P9_SHARED_BIT];
  // Both selections at once is the forbidden combination [R1]
  wire        rx1_kr_clash = kr_bit_fc && kr_bit_fe;
  // Key return only with function bit set and extension clear [R2]
  wire        kr_sel     = kr_bit_fc && !kr_bit_fe;
  wire        rx1_sel    = kr_bit_fe && !kr_bit_fc;

  // Separate 8-bit bus leaves the upper pins to the port [R8]
  wire        upper_lock = separate_bus_mode_bit &&
                           (bus_size_bits == `PCBA_BUS_SIZE_8BIT);
  wire        upper_viol = upper_lock &&
                           (data_port_function_select[15:8] != 8'h00);
  wire [15:0] fsel_eff   = upper_lock ?
                           {8'h00, data_port_function_select[7:0]} :
                           data_port_function_select;

  wire        irq7_on    = ext_irq7_falling_enable ||
                           ext_irq7_rising_enable;
  // Both users on one pin [R9] [R10]
  wire        irq7_clash = irq7_on && serial0_receive_enable;

  wire [2:0]  status_now;
  assign status_now[`PCBA_ST_RX1_KR_BIT]   = rx1_kr_clash;
  assign status_now[`PCBA_ST_UPPER_AD_BIT] = upper_viol;
  assign status_now[`PCBA_ST_IRQ7_RX0_BIT] = irq7_clash;

  // ========================================================================
  // Pin stages, all registered
  reg  [15:0] next_p9_out;
  reg  [15:0] next_p9_oe;
  reg  [15:0] next_dl_out;
  reg  [15:0] next_dl_oe;
  integer     i;

  always @* begin
    next_p9_out = 16'h0000;
    next_p9_oe  = 16'h0000;
    next_dl_out = 16'h0000;
    next_dl_oe  = 16'h0000;
    for (i = 0; i < 16; i = i + 1) begin
      // Open-drain pins only ever pull low, so a pull-up above the
      // I/O supply never fights the driver [R3]
      if (port9_open_drain_select[i]) begin
        next_p9_out[i] = 1'b0;
        next_p9_oe[i]  = p9_port_drive[i] && !p9_port_data[i];
      end else begin
        next_p9_out[i] = p9_port_data[i];
        next_p9_oe[i]  = p9_port_drive[i];
      end
      if (fsel_eff[i]) begin
        next_dl_out[i] = ad_alt_out[i];
        next_dl_oe[i]  = ad_alt_oe[i];
      end else begin
        // Direction bit 1 means input
        next_dl_out[i] = data_port_output_latch[i];
        next_dl_oe[i]  = !data_port_direction[i];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p9_pin_out           <= 16'h0000;
      p9_pin_oe            <= 16'h0000;
      dl_pin_out           <= 16'h0000;
      dl_pin_oe            <= 16'h0000;
      ad_alt_in            <= 16'h0000;
      serial1_receive_in   <= 1'b1;
      key_return_in_7      <= 1'b1;
      serial0_receive_in   <= 1'b1;
      external_interrupt_7 <= 1'b0;
    end else begin
      p9_pin_out <= next_p9_out;
      p9_pin_oe  <= next_p9_oe;
      dl_pin_out <= next_dl_out;
      dl_pin_oe  <= next_dl_oe;
      ad_alt_in  <= dl_pin_in & fsel_eff;
      // Idle-high when unselected, so a clash feeds neither unit
      serial1_receive_in <= rx1_sel ?
                            p9_pin_in[`PCBA_P9_SHARED_BIT] : 1'b1; // [R1]
      key_return_in_7    <= kr_sel ?
                            p9_pin_in[`PCBA_P9_SHARED_BIT] : 1'b1; // [R2]
      serial0_receive_in   <= serial0_receive_enable ?
                              irq7_rx0_pin_in : 1'b1;              // [R10]
      external_interrupt_7 <= irq7_on && irq7_rx0_pin_in;          // [R9]
    end
  end

  // ========================================================================
  // Read mux and answer
  reg  [31:0] next_rdata;
  reg         next_err;

  always @* begin
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    if (hit_od) begin
      next_rdata = {16'h0000, port9_open_drain_select};
    end else if (hit_od_hi) begin
      next_rdata = {24'h000000, port9_open_drain_select[15:8]}; // [R11]
    end else if (hit_lat) begin
      next_rdata = {16'h0000, data_port_output_latch};
    end else if (hit_lat_hi) begin
      next_rdata = {24'h000000, data_port_output_latch[15:8]};  // [R11]
    end else if (hit_dir) begin
      next_rdata = {16'h0000, data_port_direction};
    end else if (hit_dir_hi) begin
      next_rdata = {24'h000000, data_port_direction[15:8]};     // [R11]
    end else if (hit_fsel) begin
      next_rdata = {16'h0000, data_port_function_select};
    end else if (hit_fsel_hi) begin
      next_rdata = {24'h000000, data_port_function_select[15:8]}; // [R11]
    end else if (hit_fctrl) begin
      next_rdata = {16'h0000, port9_function_ctrl};
    end else if (hit_fext) begin
      next_rdata = {16'h0000, port9_function_ext};
    end else if (hit_bus) begin
      next_rdata = {23'h000000, separate_bus_mode_bit, bus_size_bits};
    end else if (hit_shared) begin
      next_rdata = {29'h00000000, serial0_receive_enable,
                    ext_irq7_rising_enable, ext_irq7_falling_enable};
    end else if (hit_status) begin
      next_rdata = {29'h00000000, status_now};
    end else if (hit_pins) begin
      next_rdata = {16'h0000, dl_pin_in};
    end else begin
      next_err = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h00000000 : next_rdata;
      pslverr <= next_err;
    end else begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: pcba_port_cfg_checker.sv
// Bus handshake and alias read checks for the port configuration block
`timescale 1ns/10ps
`default_nettype none

module pcba_port_cfg_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  // ==========================================================
  // Assertions
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire rd = pready && psel && !pwrite;

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held beyond one cycle");
  wait_state_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("answer not after exactly one wait state");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr outside the answer cycle");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside the answer cycle");
  od_alias_a: assert property (rd && paddr == 12'h004 |-> prdata[31:8] == 0)
    else $error("open-drain alias read wider than a byte");
  latch_alias_a: assert property (rd && paddr == 12'h00C |-> prdata[31:8] == 0)
    else $error("latch alias read wider than a byte");
  dir_alias_a: assert property (rd && paddr == 12'h014 |-> prdata[31:8] == 0)
    else $error("direction alias read wider than a byte");
  fsel_alias_a: assert property (rd && paddr == 12'h01C |-> prdata[31:8] == 0)
    else $error("function alias read wider than a byte");
endmodule

bind pcba_port_cfg pcba_port_cfg_checker chk_u (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr);

`default_nettype wire

// File: test_pcba_port_cfg.sv
// Self-checking bench for the port configuration block
`timescale 1ns/10ps
`default_nettype none
`include "pcba_consts.vh"

module test_pcba_port_cfg;
  // ==========================================================
  // Signals
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] p9_port_data = 16'h0;
  logic [15:0] p9_port_drive = 16'h0;
  logic [15:0] p9_pin_in = 16'h0;
  logic [15:0] p9_pin_out;
  logic [15:0] p9_pin_oe;
  logic        serial1_receive_in;
  logic        key_return_in_7;
  logic [15:0] dl_pin_in = 16'h0;
  logic [15:0] dl_pin_out;
  logic [15:0] dl_pin_oe;
  logic [15:0] ad_alt_out = 16'h0;
  logic [15:0] ad_alt_oe = 16'h0;
  logic [15:0] ad_alt_in;
  logic        irq7_rx0_pin_in = 1'b0;
  logic        serial0_receive_in;
  logic        external_interrupt_7;
  logic        ext_irq7_falling_enable;
  logic        ext_irq7_rising_enable;
  logic        serial0_receive_enable;
  logic [15:0] m [0:11];
  int unsigned seed = 24;
  int          n_errors = 0;
  int          num_checks = 0;

  always #5 pclk = ~pclk;

  pcba_port_cfg dut_u (.*);

  // ==========================================================
  // Helpers
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] exp_rd(input int i);
    logic sep8;
    sep8 = m[10][8] && m[10][7:0] == 8'h00;
    if (i == 12)
      return {29'h0, m[11][2] & (m[11][0] | m[11][1]),
              sep8 && m[6][15:8] != 8'h00, m[8][1] & m[9][1]};
    if (i < 8 && i % 2 == 1)
      return {24'h0, m[i-1][15:8]};
    // Pin snapshot register mirrors the data port pins
    if (i == 13)
      return {16'h0, dl_pin_in};
    return {16'h0, m[i]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50)
      n_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pins();
    logic [15:0] fe;
    logic        k1;
    logic        k2;
    fe = m[6] & ((m[10][8] && m[10][7:0] == 8'h00) ? 16'h00FF : 16'hFFFF);
    k1 = m[8][1] & ~m[9][1];
    k2 = m[9][1] & ~m[8][1];
    // Sample away from the launching edge, then hand back on a rising edge
    @(negedge pclk);
    chk({p9_pin_out, p9_pin_oe}, {p9_port_data & ~m[0],
        p9_port_drive & ~(m[0] & p9_port_data)});
    chk({dl_pin_out, dl_pin_oe}, {(fe & ad_alt_out) | (~fe & m[2]),
        (fe & ad_alt_oe) | (~fe & ~m[4])});
    chk({ad_alt_in, 9'h0, serial1_receive_in, key_return_in_7,
        serial0_receive_in, external_interrupt_7, serial0_receive_enable,
        ext_irq7_rising_enable, ext_irq7_falling_enable},
        {dl_pin_in & fe, 9'h0, k2 ? p9_pin_in[1] : 1'b1,
        k1 ? p9_pin_in[1] : 1'b1, m[11][2] ? irq7_rx0_pin_in : 1'b1,
        irq7_rx0_pin_in & (m[11][0] | m[11][1]), m[11][2:0]});
    @(posedge pclk);
  endtask

  task automatic rd(input int i);
    logic [31:0] r;
    logic        e;
    apb(1'b0, 12'(i * 4), 32'h0, 4'h0, r, e);
    chk(r, exp_rd(i));
  endtask

  task automatic wr(input int i, input logic [15:0] d, input logic [3:0] s);
    logic [31:0] r;
    logic        e;
    logic [15:0] bm;
    apb(1'b1, 12'(i * 4), {rnd() & 32'hFFFF_0000} | d, s, r, e);
    bm = {{8{s[1]}}, {8{s[0]}}};
    if (i < 8 && i % 2 == 1 && s[0])
      m[i-1][15:8] = d[7:0];
    else if (i < 12 && i % 2 == 0 || i > 7 && i < 12)
      m[i] = (m[i] & ~bm) | (d & bm & (i == 10 ? 16'h01FF :
             i == 11 ? 16'h0007 : 16'hFFFF));
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (m[x])
      m[x] = 16'h0000;
    m[4] = `PCBA_RST_DL_DIR;
    for (int i = 0; i < 14; i++)
      rd(i);
    pins();
    $display("test reset values done");
  endtask

  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Sequence
  initial begin
    logic [31:0] r;
    logic        e;
    logic [15:0] d;
    int          i;
    do_reset();
    apb(1'b1, 12'h040, 32'hFFFF_FFFF, 4'hF, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 12'h040, 32'h0, 4'h0, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test unmapped done");
    for (int k = 0; k < 300; k++) begin
      {p9_port_data, p9_port_drive} <= rnd();
      {p9_pin_in, dl_pin_in} <= rnd();
      {ad_alt_out, ad_alt_oe} <= rnd();
      irq7_rx0_pin_in <= 1'(rnd());
      i = rnd() % 14;
      d = 16'(rnd());
      // Bus size 0 or 1 so the separate 8-bit case and its release both occur
      if (i == 10)
        d = d & 16'h0101;
      wr(i, d, 4'(rnd()));
      rd(i);
      pins();
    end
    $display("test random access done");
    do_reset();
    stop_test();
  end

  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
endmodule

`default_nettype wire
